// ===== rtl/osdrm_defs.svh
/*
 * Constants of the display register map: geometry, address fields,
 * character register fields and frame control register fields.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef OSDRM_DEFS_SVH
`define OSDRM_DEFS_SVH

// Display geometry.
`define OSDRM_COLS         30
`define OSDRM_ROWS         15
`define OSDRM_CELLS        450
`define OSDRM_CELL_AW      9
`define OSDRM_FRAME_REGS   14
`define OSDRM_REG_W        16
`define OSDRM_CELL_W       17

// Address byte fields.
`define OSDRM_ROW_LSB      0
`define OSDRM_ROW_MSB      3
`define OSDRM_COL_LSB      0
`define OSDRM_COL_MSB      4
`define OSDRM_COLFMT_BIT   7
`define OSDRM_FONTTOP_BIT  7
`define OSDRM_FRAME_ROW    4'hF
`define OSDRM_FR0_COL      5'h00
`define OSDRM_FR1_COL      5'h01

// Character register fields.
`define OSDRM_CHR_BLINK    15
`define OSDRM_CHR_SHADOW   14
`define OSDRM_CHR_RAS_HI   13
`define OSDRM_CHR_RAS_LO   11
`define OSDRM_CHR_COL_HI   10
`define OSDRM_CHR_COL_LO   8
`define OSDRM_CHR_CODE_HI  7
`define OSDRM_CHR_CODE_LO  0

// Frame control register 0 fields.
`define OSDRM_F0_PROGW     10
`define OSDRM_F0_AUTO_HEIGHT     9
`define OSDRM_F0_WHITE     8
`define OSDRM_F0_EXT       7
`define OSDRM_F0_BG        6
`define OSDRM_F0_SCROLL_ENABLE     5
`define OSDRM_F0_SCROLL_PERIOD      4
`define OSDRM_F0_BLINK_ENABLE     3
`define OSDRM_F0_BLINK_PERIOD      2
`define OSDRM_F0_ERASE     1
`define OSDRM_F0_EN        0
`define OSDRM_F0_MASK      16'h07FF

// Frame control register 1 fields.
`define OSDRM_F1_LOOP_HI   15
`define OSDRM_F1_LOOP_LO   13
`define OSDRM_F1_FREQ_HI   12
`define OSDRM_F1_FREQ_LO   10
`define OSDRM_F1_DOT_HI    9
`define OSDRM_F1_DOT_LO    8
`define OSDRM_F1_HFLYBACK_POLARITY      7
`define OSDRM_F1_VFLYBACK_POLARITY      6
`define OSDRM_F1_HGT_HI    5
`define OSDRM_F1_HGT_LO    0

// Reset values.
`define OSDRM_REG_RST      16'h0000
`define OSDRM_CELL_RST     17'h00000

`endif

// ===== rtl/osdrm_pkg.sv
/*
 * Types of the display register map.
 * Assumes the constants header is on the include path.
 */
`include "osdrm_defs.svh"

package osdrm_pkg;

  // Whole state of the register map top.
  typedef struct packed {
    logic [`OSDRM_FRAME_REGS-1:0][`OSDRM_REG_W-1:0] frame;
    logic                                  eraseBusy;
    logic [`OSDRM_CELL_AW-1:0]             eraseIdx;
    logic                                  rdPend;
    logic                                  rdIsFrame;
    logic [`OSDRM_REG_W-1:0]               rdFrameVal;
    logic                                  rdValid;
    logic [`OSDRM_REG_W-1:0]               rdData;
    logic [8:0]                            rdFontAddr;
    logic                                  rdBlink;
    logic                                  rdShadow;
    logic [1:0]                            rdExtSel;
    logic [2:0]                            rdRasterColor;
    logic [2:0]                            rdGlyphColor;
    logic                                  rdVisible;
  } osdrm_state_t;

endpackage

// ===== rtl/osdrm_cell_mem.sv
/*
 * Character cell memory: one write port, one read port, read data
 * registered. Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "osdrm_defs.svh"

module osdrm_cell_mem #(
  parameter int WIDTH = `OSDRM_CELL_W,
  parameter int DEPTH = `OSDRM_CELLS,
  parameter int AW    = `OSDRM_CELL_AW
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             we,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] cells [DEPTH];

  // Storage write and registered read.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      cells[wrAddr] <= wrData;
    end
    if (sys_rst) begin
      rdData <= '0;
    end else begin
      rdData <= cells[rdAddr];
    end
  end

endmodule

// ===== rtl/osdrm_regmap.sv
/*
 * Display register map of the on-screen display: character cells in
 * rows 0 to 14 and frame control registers in row 15, written from the
 * serial data receiver as a row byte, a column byte and a 16-bit word,
 * and read by the display engine or the receiver through one read port.
 * Assumes the receiver hands over one decoded write per wrEn pulse.
 */
// Overview of operation
// RQ1 - Host changes data only while clock low.
// RQ2 - Memory addressed by row and column.
// RQ3 - One cell register per 30x15 location.
// RQ4 - Every display register is sixteen bits.
// RQ5 - Font index is low byte plus one.
// RQ6 - Upper byte gives cell attributes.
// RQ7 - Frame control registers live in row 15.
// RQ8 - Frame registers 0-2 hold global controls.
// RQ9 - Frame register 3 picks extended codes.
// RQ10 - Frame register 4 holds height, spacing.
// RQ11 - Frame registers 5-13 configure four windows.
// RQ12 - Bit 15 blinks, else extended high select.
// RQ13 - Bit 14 shadows, else extended low select.
// RQ14 - Raster color, glyph color, glyph code.
// RQ15 - Frame register 0 control bit layout.
// RQ16 - Frame register 1 loop, freq, height.
// RQ17 - Column top bit used when enabled.
// RQ18 - Overlay shown only with display enabled.
// RQ19 - Unused frame register 0 bits ignored.
`timescale 1ns/10ps
`include "osdrm_defs.svh"

module osdrm_regmap #(
  parameter int COLS       = `OSDRM_COLS,
  parameter int ROWS       = `OSDRM_ROWS,
  parameter int FRAME_REGS = `OSDRM_FRAME_REGS
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrRowAddr,
  input  wire logic [7:0]  wrColAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire logic [3:0]  rdRow,
  input  wire logic [4:0]  rdCol,
  output logic             rdValid,
  output logic [15:0]      rdData,
  output logic [8:0]       rdFontAddr,
  output logic             rdBlink,
  output logic             rdShadow,
  output logic [1:0]       rdExtSel,
  output logic [2:0]       rdRasterColor,
  output logic [2:0]       rdGlyphColor,
  output logic             rdVisible,
  output logic             displayEnable,
  output logic             ramEraseBusy,
  output logic             blinkPeriod,
  output logic             blinkEnable,
  output logic             scrollPeriod,
  output logic             scrollEnable,
  output logic             backgroundTransparent,
  output logic             extCodeEnable,
  output logic             whitePattern,
  output logic             autoHeight,
  output logic             progWhiteEnable,
  output logic [2:0]       loopCtrl,
  output logic [2:0]       lineFreqSel,
  output logic [1:0]       dotSel,
  output logic             hflybackPolarity,
  output logic             vflybackPolarity,
  output logic [5:0]       glyphHeight,
  output logic [191:0]     frameAuxRegs
);

  ////////////////////////////////////////////////////////////////////////

  osdrm_pkg::osdrm_state_t st;
  osdrm_pkg::osdrm_state_t next_st;

  logic                       memWe;
  logic [`OSDRM_CELL_AW-1:0]  memWrAddr;
  logic [`OSDRM_CELL_W-1:0]   memWrData;
  logic [`OSDRM_CELL_AW-1:0]  memRdAddr;
  logic [`OSDRM_CELL_W-1:0]   memRdData;
  logic [3:0]                 wrRow;
  logic [4:0]                 wrCol;
  logic                       wrFrame;
  logic                       wrCell;
  logic                       fontTop;
  logic                       rdInCells;
  logic [`OSDRM_REG_W-1:0]    stageData;

  // Linear cell index of a row and column, laid out row after row.
  function automatic logic [`OSDRM_CELL_AW-1:0] cellIndex(
    input logic [3:0] row,
    input logic [4:0] col
  );
    logic [`OSDRM_CELL_AW-1:0] idx;
    idx = `OSDRM_CELL_AW'(row * COLS + col);
    return idx;
  endfunction

  // Cell storage with registered read data.
  osdrm_cell_mem #(
    .WIDTH (`OSDRM_CELL_W),
    .DEPTH (`OSDRM_CELLS),
    .AW    (`OSDRM_CELL_AW)
  ) u_cells (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .we      (memWe),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdAddr  (memRdAddr),
    .rdData  (memRdData)
  );

  ////////////////////////////////////////////////////////////////////////

  // Decode of the write address bytes.
  // RQ2 row column decode
  assign wrRow     = wrRowAddr[`OSDRM_ROW_MSB:`OSDRM_ROW_LSB];
  assign wrCol     = wrColAddr[`OSDRM_COL_MSB:`OSDRM_COL_LSB];
  // RQ7 frame row select
  assign wrFrame   = wrEn && wrRow == `OSDRM_FRAME_ROW
                     && wrCol < 5'(FRAME_REGS);
  // RQ3 cell range check
  assign wrCell    = wrEn && wrRow < 4'(ROWS) && wrCol < 5'(COLS);
  // RQ17 font top gating
  assign fontTop   = wrRowAddr[`OSDRM_COLFMT_BIT]
                     & wrColAddr[`OSDRM_FONTTOP_BIT];
  assign rdInCells = rdRow < 4'(ROWS) && rdCol < 5'(COLS);
  assign memRdAddr = rdInCells ? cellIndex(rdRow, rdCol) : '0;
  assign stageData = st.rdIsFrame ? st.rdFrameVal
                                  : memRdData[`OSDRM_REG_W-1:0];

  // Next state: erase walk, host writes, read pipeline.
  always_comb begin
    next_st   = st;
    memWe     = 1'b0;
    memWrAddr = '0;
    memWrData = `OSDRM_CELL_RST;
    // RQ15 erase walk clears
    if (st.eraseBusy) begin
      memWe     = 1'b1;
      memWrAddr = st.eraseIdx;
      if (st.eraseIdx == `OSDRM_CELL_AW'(`OSDRM_CELLS - 1)) begin
        next_st.eraseBusy                  = 1'b0;
        next_st.frame[0][`OSDRM_F0_ERASE]  = 1'b0;
      end else begin
        next_st.eraseIdx = st.eraseIdx + 1'b1;
      end
    end
    if (wrFrame) begin
      if (wrCol == `OSDRM_FR0_COL) begin
        // RQ19 upper bits dropped
        next_st.frame[0] = wrData & `OSDRM_F0_MASK;
        if (wrData[`OSDRM_F0_ERASE]) begin
          next_st.eraseBusy = 1'b1;
          next_st.eraseIdx  = '0;
        end
      end else begin
        // RQ11 frame word store
        next_st.frame[wrCol[3:0]] = wrData;
      end
    end else if (wrCell && !st.eraseBusy) begin
      // RQ4 sixteen bit word plus font top bit store
      memWe     = 1'b1;
      memWrAddr = cellIndex(wrRow, wrCol);
      memWrData = {fontTop, wrData};
    end
    // Stage one: capture the request and any frame word.
    next_st.rdPend     = rdEn;
    next_st.rdIsFrame  = !rdInCells;
    next_st.rdFrameVal = `OSDRM_REG_RST;
    if (rdRow == `OSDRM_FRAME_ROW && rdCol < 5'(FRAME_REGS)) begin
      next_st.rdFrameVal = st.frame[rdCol[3:0]];
    end
    // Stage two: decode the word and register the result.
    next_st.rdValid = st.rdPend;
    next_st.rdData  = stageData;
    // RQ5 nine bit font
    next_st.rdFontAddr = st.rdIsFrame ? 9'h000
      : {memRdData[`OSDRM_CELL_W-1],
         stageData[`OSDRM_CHR_CODE_HI:`OSDRM_CHR_CODE_LO]};
    // RQ12 blink or select
    next_st.rdBlink  = stageData[`OSDRM_CHR_BLINK]
                       & ~st.frame[0][`OSDRM_F0_EXT];
    // RQ13 shadow or select
    next_st.rdShadow = stageData[`OSDRM_CHR_SHADOW]
                       & ~st.frame[0][`OSDRM_F0_EXT];
    // RQ9 extended code select
    next_st.rdExtSel = st.frame[0][`OSDRM_F0_EXT]
      ? stageData[`OSDRM_CHR_BLINK:`OSDRM_CHR_SHADOW] : 2'h0;
    // RQ6 attribute byte split
    next_st.rdRasterColor =
      stageData[`OSDRM_CHR_RAS_HI:`OSDRM_CHR_RAS_LO];
    // RQ14 glyph color field
    next_st.rdGlyphColor  =
      stageData[`OSDRM_CHR_COL_HI:`OSDRM_CHR_COL_LO];
    // RQ18 overlay gated off
    next_st.rdVisible = st.rdPend && !st.rdIsFrame
                        && st.frame[0][`OSDRM_F0_EN];
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // Read port outputs, all straight from state flops.
  assign rdValid       = st.rdValid;
  assign rdData        = st.rdData;
  assign rdFontAddr    = st.rdFontAddr;
  assign rdBlink       = st.rdBlink;
  assign rdShadow      = st.rdShadow;
  assign rdExtSel      = st.rdExtSel;
  assign rdRasterColor = st.rdRasterColor;
  assign rdGlyphColor  = st.rdGlyphColor;
  assign rdVisible     = st.rdVisible;

  // RQ8 global control fields
  assign displayEnable         = st.frame[0][`OSDRM_F0_EN];
  assign ramEraseBusy          = st.eraseBusy;
  assign blinkPeriod           = st.frame[0][`OSDRM_F0_BLINK_PERIOD];
  assign blinkEnable           = st.frame[0][`OSDRM_F0_BLINK_ENABLE];
  assign scrollPeriod          = st.frame[0][`OSDRM_F0_SCROLL_PERIOD];
  assign scrollEnable          = st.frame[0][`OSDRM_F0_SCROLL_ENABLE];
  assign backgroundTransparent = st.frame[0][`OSDRM_F0_BG];
  assign extCodeEnable         = st.frame[0][`OSDRM_F0_EXT];
  assign whitePattern          = st.frame[0][`OSDRM_F0_WHITE];
  assign autoHeight            = st.frame[0][`OSDRM_F0_AUTO_HEIGHT];
  assign progWhiteEnable       = st.frame[0][`OSDRM_F0_PROGW];

  // RQ16 register one fields
  assign loopCtrl         = st.frame[1][`OSDRM_F1_LOOP_HI:`OSDRM_F1_LOOP_LO];
  assign lineFreqSel      = st.frame[1][`OSDRM_F1_FREQ_HI:`OSDRM_F1_FREQ_LO];
  assign dotSel           = st.frame[1][`OSDRM_F1_DOT_HI:`OSDRM_F1_DOT_LO];
  assign hflybackPolarity = st.frame[1][`OSDRM_F1_HFLYBACK_POLARITY];
  assign vflybackPolarity = st.frame[1][`OSDRM_F1_VFLYBACK_POLARITY];
  assign glyphHeight      = st.frame[1][`OSDRM_F1_HGT_HI:`OSDRM_F1_HGT_LO];

  // RQ10 aux registers out
  genvar g;
  generate
    for (g = 2; g < FRAME_REGS; g++) begin : gAux
      assign frameAuxRegs[(g-2)*`OSDRM_REG_W +: `OSDRM_REG_W] = st.frame[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Erase steps: a kick, then the last cell of the walk.
  sequence eraseKick;
    wrFrame && wrCol == `OSDRM_FR0_COL && wrData[`OSDRM_F0_ERASE];
  endsequence
  sequence eraseLast;
    st.eraseBusy && st.eraseIdx == `OSDRM_CELL_AW'(`OSDRM_CELLS - 1)
      && !wrFrame;
  endsequence

  a_frame0_unused: assert property ( // RQ19
    st.frame[0][15:11] == 5'h00)
    else $error("Unused frame register 0 bits became set.");

  a_erase_start: assert property ( // RQ15
    eraseKick |=> ramEraseBusy && st.eraseIdx == '0)
    else $error("RAM erase did not start after the erase bit.");

  a_erase_end: assert property ( // RQ15
    eraseLast |=> !ramEraseBusy && !st.frame[0][`OSDRM_F0_ERASE])
    else $error("RAM erase did not finish after the last cell.");

  a_read_latency: assert property ( // RQ2
    rdEn |-> ##2 rdValid)
    else $error("Read data not valid two cycles after request.");

  a_font_low_byte: assert property ( // RQ5
    rdValid |-> rdFontAddr[7:0] == (rdVisible || !$past(st.rdIsFrame)
      ? rdData[7:0] : 8'h00))
    else $error("Font address low byte does not follow the cell.");

  a_ext_blink: assert property ( // RQ12
    rdValid && $past(extCodeEnable) |->
      !rdBlink && rdExtSel[1] == rdData[15])
    else $error("Blink bit not turned into extended select.");

  a_shadow_plain: assert property ( // RQ13
    rdValid && !$past(extCodeEnable) |->
      rdShadow == rdData[14] && rdExtSel == 2'h0)
    else $error("Shadow bit wrong without extended codes.");

  a_raster_field: assert property ( // RQ14
    rdValid |-> rdRasterColor == rdData[13:11]
      && rdGlyphColor == rdData[10:8])
    else $error("Color fields do not match the cell word.");

  a_overlay_gate: assert property ( // RQ18
    rdVisible |-> $past(displayEnable) && rdValid)
    else $error("Overlay shown while display was disabled.");

  a_frame1_write: assert property ( // RQ16
    wrFrame && wrCol == `OSDRM_FR1_COL |=>
      st.frame[1] == $past(wrData))
    else $error("Frame register 1 did not take the written word.");

endmodule

// ===== tb/osdrm_host_model.sv
/*
 * Behavioural model of the controlling microcontroller, seen through the
 * serial receiver as one decoded word write per strobe.
 * Assumes its task is called at a falling edge of ref_clk.
 */
`timescale 1ns/10ps

module osdrm_host_model (
  input  wire logic        ref_clk,
  output logic             wrEn,
  output logic [7:0]       wrRowAddr,
  output logic [7:0]       wrColAddr,
  output logic [15:0]      wrData
);

  // Idle lines start low until the first write.
  initial begin
    wrEn = 1'b0;
    wrRowAddr = 8'h00;
    wrColAddr = 8'h00;
    wrData = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // change away from sampling
  // column format for upper fonts
  // Drives one word for a single cycle, then idles one cycle so that two
  // calls never touch the strobe twice in one time step.
  // The topBits argument is {row bit7, col bit7}.
  task automatic writeWord(input logic [3:0]  row,
                           input logic [4:0]  col,
                           input logic [15:0] data,
                           input logic [1:0]  topBits);
    wrEn = 1'b1;
    wrRowAddr = {topBits[1], 3'h0, row};
    wrColAddr = {topBits[0], 2'h0, col};
    wrData = data;
    @(negedge ref_clk);
    wrEn = 1'b0;
    wrRowAddr = ~wrRowAddr; // Released lines must not hold stale values.
    wrColAddr = ~wrColAddr;
    wrData = ~wrData;
    @(negedge ref_clk);
  endtask

endmodule

// ===== tb/osdrm_regmap_test.sv
/*
 * Self-checking bench of the display register map, writing through the
 * host model and reading through the read port.
 * Assumes a 25 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps

module osdrm_regmap_test;
  logic         ref_clk;
  logic         sys_rst;
  logic         wrEn;
  logic [7:0]   wrRowAddr;
  logic [7:0]   wrColAddr;
  logic [15:0]  wrData;
  logic         rdEn;
  logic [3:0]   rdRow;
  logic [4:0]   rdCol;
  logic         rdValid;
  logic [15:0]  rdData;
  logic [8:0]   rdFontAddr;
  logic         rdBlink, rdShadow, rdVisible;
  logic [1:0]   rdExtSel, dotSel;
  logic [2:0]   rdRasterColor, rdGlyphColor, loopCtrl, lineFreqSel;
  logic         displayEnable, ramEraseBusy, blinkPeriod, blinkEnable;
  logic         scrollPeriod, scrollEnable, backgroundTransparent;
  logic         extCodeEnable, whitePattern, autoHeight, progWhiteEnable;
  logic         hflybackPolarity, vflybackPolarity;
  logic [5:0]   glyphHeight;
  logic [191:0] frameAuxRegs;
  int           fails;
  int           testsRun;
  int           n;

  osdrm_host_model osdrm_host_model_i (.ref_clk(ref_clk), .wrEn(wrEn),
    .wrRowAddr(wrRowAddr), .wrColAddr(wrColAddr), .wrData(wrData));

  osdrm_regmap osdrm_regmap_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wrEn(wrEn), .wrRowAddr(wrRowAddr), .wrColAddr(wrColAddr),
    .wrData(wrData), .rdEn(rdEn), .rdRow(rdRow), .rdCol(rdCol),
    .rdValid(rdValid), .rdData(rdData), .rdFontAddr(rdFontAddr),
    .rdBlink(rdBlink), .rdShadow(rdShadow), .rdExtSel(rdExtSel),
    .rdRasterColor(rdRasterColor), .rdGlyphColor(rdGlyphColor),
    .rdVisible(rdVisible), .displayEnable(displayEnable),
    .ramEraseBusy(ramEraseBusy), .blinkPeriod(blinkPeriod),
    .blinkEnable(blinkEnable), .scrollPeriod(scrollPeriod),
    .scrollEnable(scrollEnable),
    .backgroundTransparent(backgroundTransparent),
    .extCodeEnable(extCodeEnable), .whitePattern(whitePattern),
    .autoHeight(autoHeight), .progWhiteEnable(progWhiteEnable),
    .loopCtrl(loopCtrl), .lineFreqSel(lineFreqSel), .dotSel(dotSel),
    .hflybackPolarity(hflybackPolarity),
    .vflybackPolarity(vflybackPolarity), .glyphHeight(glyphHeight),
    .frameAuxRegs(frameAuxRegs));

  ////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns period.
  always #20 ref_clk = ~ref_clk;

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Issues one read and returns at the falling edge while the answer
  // stands, since rdValid is high for one cycle only.
  task automatic readWord(input logic [3:0] row, input logic [4:0] col);
    rdEn = 1'b1;
    rdRow = row;
    rdCol = col;
    @(negedge ref_clk);
    rdEn = 1'b0;
    rdRow = ~row;
    rdCol = ~col;
    @(negedge ref_clk);
    check({15'h0000, rdValid}, 16'h0001);
  endtask

  // Attribute outputs of the last read packed into one word.
  function automatic logic [15:0] attrs();
    return {5'h00, rdBlink, rdShadow, rdExtSel, rdRasterColor,
            rdGlyphColor, rdVisible};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short well beyond the expected run.
  initial begin
    #800000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    stopTest();
  end

  // Main test sequence.
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    rdEn = 1'b0;
    rdRow = 4'h0;
    rdCol = 5'h00;
    fails = 0;
    testsRun = 0;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check({15'h0000, displayEnable}, 16'h0000);
    check(frameAuxRegs[15:0], 16'h0000);
    $display("test reset done");

    osdrm_host_model_i.writeWord(4'hF, 5'h00, 16'hFFFD, 2'b00);
    check({5'h00, progWhiteEnable, autoHeight, whitePattern, extCodeEnable,
           backgroundTransparent, scrollEnable, scrollPeriod, blinkEnable,
           blinkPeriod, ramEraseBusy, displayEnable}, 16'h07FD);
    readWord(4'hF, 5'h00);
    check(rdData, 16'h07FD);
    osdrm_host_model_i.writeWord(4'hF, 5'h01, 16'hA5C3, 2'b00);
    check({loopCtrl, lineFreqSel, dotSel, hflybackPolarity,
           vflybackPolarity, glyphHeight}, 16'hA5C3);
    readWord(4'hF, 5'h01);
    check(rdData, 16'hA5C3);
    $display("test frame control done");

    for (int k = 2; k < 14; k++) begin
      osdrm_host_model_i.writeWord(4'hF, 5'(k), 16'(k) * 16'h1111, 2'b00);
    end
    osdrm_host_model_i.writeWord(4'hF, 5'h0E, 16'hBEEF, 2'b00);
    for (int k = 2; k < 14; k++) begin
      check(frameAuxRegs[(k-2)*16 +: 16], 16'(k) * 16'h1111);
    end
    check(frameAuxRegs[31:16], 16'h3333);
    check(frameAuxRegs[47:32], 16'h4444);
    readWord(4'hF, 5'h0E);
    check(rdData, 16'h0000);
    $display("test auxiliary frame done");

    osdrm_host_model_i.writeWord(4'hF, 5'h00, 16'h0001, 2'b00);
    osdrm_host_model_i.writeWord(4'h3, 5'h07, 16'hD6A5, 2'b11);
    osdrm_host_model_i.writeWord(4'h4, 5'h08, 16'h1234, 2'b10);
    readWord(4'h3, 5'h07);
    check(rdData, 16'hD6A5);
    check({7'h00, rdFontAddr}, 16'h01A5);
    check(attrs(), 16'h062D);
    check({10'h000, rdRasterColor, rdGlyphColor}, 16'h0016);
    readWord(4'h4, 5'h08);
    check({7'h00, rdFontAddr}, 16'h0034);
    osdrm_host_model_i.writeWord(4'hF, 5'h00, 16'h0081, 2'b00);
    readWord(4'h3, 5'h07);
    check(attrs(), 16'h01AD);
    osdrm_host_model_i.writeWord(4'hF, 5'h00, 16'h0080, 2'b00);
    readWord(4'h3, 5'h07);
    check(attrs(), 16'h01AC);
    $display("test cell attributes done");

    osdrm_host_model_i.writeWord(4'h1, 5'h00, 16'h1111, 2'b00);
    osdrm_host_model_i.writeWord(4'h0, 5'h1E, 16'h2222, 2'b00);
    osdrm_host_model_i.writeWord(4'hE, 5'h1D, 16'h3333, 2'b00);
    osdrm_host_model_i.writeWord(4'h0, 5'h00, 16'h4444, 2'b00);
    readWord(4'h1, 5'h00);
    check(rdData, 16'h1111);
    readWord(4'hE, 5'h1D);
    check(rdData, 16'h3333);
    readWord(4'h0, 5'h00);
    check(rdData, 16'h4444);
    readWord(4'h0, 5'h1E);
    check(rdData, 16'h0000);
    $display("test cell boundaries done");

    osdrm_host_model_i.writeWord(4'hF, 5'h00, 16'h0003, 2'b00);
    // The idle tail of the write already spent one busy cycle.
    n = 1;
    while (ramEraseBusy === 1'b1 && n < 1000) begin
      if (n == 200) begin
        osdrm_host_model_i.writeWord(4'h3, 5'h07, 16'h5A5A, 2'b00);
        n++;
      end else begin
        @(negedge ref_clk);
      end
      n++;
    end
    check(16'(n), 16'h01C2);
    readWord(4'h3, 5'h07);
    check(rdData, 16'h0000);
    readWord(4'hE, 5'h1D);
    check(rdData, 16'h0000);
    readWord(4'hF, 5'h00);
    check(rdData, 16'h0001);
    $display("test erase done");
    stopTest();
  end

endmodule
